// ==== src/mpsr_pkg.sv ====
// Purpose: Constants and types for the modem pump status register bank.
// Assumes: 8-bit host register bus with 3-bit register select.
// Notes: Overview below lists the behaviour kept by the bank.
// Overview of operation
// - Bit 0 high while in reset state
// - Bit 0 clears when reset cycle ends
// - Carrier flag set on entering data mode
// - Carrier flag clears on retrain or no signal
// - Line signal pin is inverted carrier flag
// - Carrier flag cleared by reset or standby
// - Retrain flag set only in 2400 mode
// - Busy set when sending with send request
// - Busy holds until send request drops and internal buffers drain
// - Busy also set while dialing digits
// - Busy cleared by reset or standby
// - Memory done flag set after RAM request
// - Rx ready set on new parallel octet
// - Host read of data clears rx ready
// - Tx taken set on consumed parallel octet
// - Host write of data clears tx taken
// - After reset rx ready one, others zero
// - Irq is OR of enabled three flags
// - Path select chooses parallel or serial
// - Send request is bit OR pin
`default_nettype none
package mpsr_pkg;
  localparam logic [2:0] ADDR_RAM_LO = 3'h0;
  localparam logic [2:0] ADDR_RAM_HI = 3'h1;
  localparam logic [2:0] ADDR_RAM_ADR = 3'h2;
  localparam logic [2:0] ADDR_DATA = 3'h3;
  localparam logic [2:0] ADDR_CTRL = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;
  localparam logic [2:0] ADDR_FRAME = 3'h7;
  // Control register field positions
  localparam int CTRL_RAM_AHI = 0;
  localparam int CTRL_RAM_REQ = 1;
  localparam int CTRL_RAM_WR = 2;
  localparam int CTRL_SEND_REQ = 3;
  localparam int CTRL_PAR_SEL = 4;
  localparam int CTRL_MEM_IE = 5;
  localparam int CTRL_RX_IE = 6;
  localparam int CTRL_TX_IE = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_AFTER_INIT = 8'h40;
  localparam logic [7:0] FRAME_RESET = 8'h00;
  localparam logic [7:0] FRAME_WR_MASK = 8'h07;
  // Internal reset cycle length
  localparam int INIT_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef struct packed {
    logic tx_octet_taken;
    logic rx_octet_ready;
    logic mem_access_done;
    logic pump_transmitting;
    logic reserved;
    logic retrain_seen;
    logic carrier_present_flag;
    logic init_cycle_active;
  } mpsr_status_s;
  typedef struct packed {
    logic data_mode_ready;
    logic retrain_active;
    logic signal_lost;
    logic retrain_request;
    logic mode_2400;
    logic tx_data_started;
    logic tx_buffers_empty;
    logic dialing;
    logic frame_mode;
    logic standby;
  } mpsr_pump_s;
  typedef enum logic [1:0] {MPSR_INIT, MPSR_RUN} mpsr_state_e;
endpackage
`default_nettype wire

// ==== src/mpsr_top.sv ====
// Purpose: Host status register bank of a modem data pump.
// Assumes: Host bus strobes are one-cycle pulses synchronous to REF_CLK.
// Notes: Reads are registered; RD_DATA is valid the cycle after RD_STB.
`default_nettype none
module mpsr_top #(
  parameter int INIT_CYCLES = mpsr_pkg::INIT_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic [2:0] ADDR,
  input wire logic RD_STB,
  input wire logic WR_STB,
  input wire logic [7:0] WR_DATA,
  output logic [7:0] RD_DATA,
  input wire logic RTS_PIN,
  input wire mpsr_pkg::mpsr_pump_s PUMP,
  input wire logic RX_OCTET_STB,
  input wire logic [7:0] RX_OCTET,
  input wire logic TX_OCTET_STB,
  output logic [7:0] TX_OCTET,
  input wire logic MEM_DONE_STB,
  input wire logic [15:0] MEM_RD_DATA,
  output logic [8:0] MEM_ADDR,
  output logic [15:0] MEM_WR_DATA,
  output logic MEM_WR,
  output logic MEM_REQ,
  output logic SEND_REQUEST,
  output logic PARALLEL_MODE,
  output logic LINE_SIGNAL_OUT_N,
  output logic HOST_IRQ_OUT
);
  mpsr_pkg::mpsr_status_s status;
  mpsr_pkg::mpsr_state_e state;
  logic [7:0] ctrl;
  logic [7:0] ram_lo;
  logic [7:0] ram_hi;
  logic [7:0] ram_adr;
  logic [7:0] par_data;
  logic [7:0] frame;
  logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt;
  logic running;
  logic rd_data_reg;
  logic wr_data_reg;
  logic par_sel;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    hit = (a == r);
  endfunction

  assign running = (state == mpsr_pkg::MPSR_RUN);
  assign rd_data_reg = RD_STB && hit(ADDR, mpsr_pkg::ADDR_DATA);
  assign wr_data_reg = WR_STB && hit(ADDR, mpsr_pkg::ADDR_DATA);
  assign par_sel = ctrl[mpsr_pkg::CTRL_PAR_SEL];

  // Internal reset cycle
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= mpsr_pkg::MPSR_INIT;
      init_cnt <= '0;
    end else begin
      case (state)
        mpsr_pkg::MPSR_INIT: begin
          if (init_cnt == ($clog2(INIT_CYCLES+1))'(INIT_CYCLES - 1)) begin
            state <= mpsr_pkg::MPSR_RUN;
          end else begin
            init_cnt <= init_cnt + 1'b1;
          end
        end
        mpsr_pkg::MPSR_RUN: state <= mpsr_pkg::MPSR_RUN;
        default: state <= mpsr_pkg::MPSR_INIT;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status.init_cycle_active <= 1'b1;
    end else begin
      // Held one cycle into run so that cycle can raise rx ready
      status.init_cycle_active <= !running;
    end
  end
  assign status.reserved = 1'b0;

  // Carrier flag: standby and retrain beat data mode entry
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status.carrier_present_flag <= 1'b0;
    end else if (!running || PUMP.standby) begin
      status.carrier_present_flag <= 1'b0;
    end else if (PUMP.retrain_active || PUMP.signal_lost) begin
      status.carrier_present_flag <= 1'b0;
    end else if (PUMP.data_mode_ready) begin
      status.carrier_present_flag <= 1'b1;
    end
  end
  assign LINE_SIGNAL_OUT_N = !status.carrier_present_flag;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status.retrain_seen <= 1'b0;
    end else if (!running || PUMP.standby || !PUMP.mode_2400) begin
      status.retrain_seen <= 1'b0;
    end else if (PUMP.retrain_request) begin
      status.retrain_seen <= 1'b1;
    end
  end

  // Busy; meaningless in frame mode, so left unqualified by it
  assign SEND_REQUEST = ctrl[mpsr_pkg::CTRL_SEND_REQ] || RTS_PIN;
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status.pump_transmitting <= 1'b0;
    end else if (!running || PUMP.standby) begin
      status.pump_transmitting <= 1'b0;
    end else if (PUMP.dialing || (PUMP.tx_data_started && SEND_REQUEST)) begin
      status.pump_transmitting <= 1'b1;
    end else if (!SEND_REQUEST && PUMP.tx_buffers_empty) begin
      status.pump_transmitting <= 1'b0;
    end
  end

  // Event flags: set wins over clear in the same cycle
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status.mem_access_done <= 1'b0;
    end else if (!running) begin
      status.mem_access_done <= 1'b0;
    end else if (MEM_DONE_STB) begin
      status.mem_access_done <= 1'b1;
    end else if (WR_STB && hit(ADDR, mpsr_pkg::ADDR_CTRL) &&
                 WR_DATA[mpsr_pkg::CTRL_RAM_REQ]) begin
      status.mem_access_done <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status.rx_octet_ready <= 1'b0;
    end else if (!running) begin
      status.rx_octet_ready <= 1'b0;
    end else if (state == mpsr_pkg::MPSR_RUN && status.init_cycle_active) begin
      status.rx_octet_ready <= 1'b1;
    end else if (RX_OCTET_STB && par_sel) begin
      status.rx_octet_ready <= 1'b1;
    end else if (rd_data_reg) begin
      status.rx_octet_ready <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status.tx_octet_taken <= 1'b0;
    end else if (!running) begin
      status.tx_octet_taken <= 1'b0;
    end else if (TX_OCTET_STB && par_sel) begin
      status.tx_octet_taken <= 1'b1;
    end else if (wr_data_reg) begin
      status.tx_octet_taken <= 1'b0;
    end
  end

  assign HOST_IRQ_OUT = (status.mem_access_done && ctrl[mpsr_pkg::CTRL_MEM_IE]) ||
    (status.rx_octet_ready && ctrl[mpsr_pkg::CTRL_RX_IE]) ||
    (status.tx_octet_taken && ctrl[mpsr_pkg::CTRL_TX_IE]);

  // Control register; pump clears the request when done
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= mpsr_pkg::CTRL_RESET;
    end else if (!running) begin
      ctrl <= mpsr_pkg::CTRL_RESET;
    end else if (WR_STB && hit(ADDR, mpsr_pkg::ADDR_CTRL)) begin
      ctrl <= WR_DATA;
    end else if (MEM_DONE_STB) begin
      ctrl[mpsr_pkg::CTRL_RAM_REQ] <= 1'b0;
    end
  end
  assign PARALLEL_MODE = par_sel;
  assign MEM_REQ = ctrl[mpsr_pkg::CTRL_RAM_REQ];
  assign MEM_WR = ctrl[mpsr_pkg::CTRL_RAM_WR];
  assign MEM_ADDR = {ctrl[mpsr_pkg::CTRL_RAM_AHI], ram_adr};
  assign MEM_WR_DATA = {ram_hi, ram_lo};

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ram_lo <= 8'h00;
      ram_hi <= 8'h00;
      ram_adr <= 8'h00;
    end else if (MEM_DONE_STB && !MEM_WR) begin
      ram_lo <= MEM_RD_DATA[7:0];
      ram_hi <= MEM_RD_DATA[15:8];
    end else if (WR_STB) begin
      if (hit(ADDR, mpsr_pkg::ADDR_RAM_LO)) ram_lo <= WR_DATA;
      if (hit(ADDR, mpsr_pkg::ADDR_RAM_HI)) ram_hi <= WR_DATA;
      if (hit(ADDR, mpsr_pkg::ADDR_RAM_ADR)) ram_adr <= WR_DATA;
    end
  end

  // Parallel data: receive overwrites a pending host byte
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      par_data <= 8'h00;
    end else if (RX_OCTET_STB && par_sel) begin
      par_data <= RX_OCTET;
    end else if (wr_data_reg) begin
      par_data <= WR_DATA;
    end
  end
  assign TX_OCTET = par_data;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      frame <= mpsr_pkg::FRAME_RESET;
    end else if (!running || PUMP.standby) begin
      frame <= mpsr_pkg::FRAME_RESET;
    end else if (WR_STB && hit(ADDR, mpsr_pkg::ADDR_FRAME)) begin
      frame <= WR_DATA & mpsr_pkg::FRAME_WR_MASK;
    end
  end

  // Status register itself is read-only: no write path exists
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RD_DATA <= 8'h00;
    end else if (RD_STB) begin
      case (ADDR)
        mpsr_pkg::ADDR_RAM_LO: RD_DATA <= ram_lo;
        mpsr_pkg::ADDR_RAM_HI: RD_DATA <= ram_hi;
        mpsr_pkg::ADDR_DATA: RD_DATA <= par_data;
        mpsr_pkg::ADDR_CTRL: RD_DATA <= ctrl;
        mpsr_pkg::ADDR_STATUS: RD_DATA <= status;
        mpsr_pkg::ADDR_FRAME: RD_DATA <= frame;
        default: RD_DATA <= 8'h00;
      endcase
    end
  end

  property p_irq;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (status.rx_octet_ready && ctrl[mpsr_pkg::CTRL_RX_IE]) |-> HOST_IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_pin;
    @(posedge REF_CLK) disable iff (!RESET_N)
    LINE_SIGNAL_OUT_N != status.carrier_present_flag;
  endproperty
  a_pin: assert property (p_pin) else $error("line pin wrong");
  property p_stby;
    @(posedge REF_CLK) disable iff (!RESET_N)
    PUMP.standby |=> !status.carrier_present_flag && !status.pump_transmitting;
  endproperty
  a_stby: assert property (p_stby) else $error("standby not cleared");
  property p_rxclr;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (rd_data_reg && running && !status.init_cycle_active && !RX_OCTET_STB)
      |=> !status.rx_octet_ready;
  endproperty
  a_rxclr: assert property (p_rxclr) else $error("rx ready kept");
  property p_rxset;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (RX_OCTET_STB && par_sel && running) |=> status.rx_octet_ready;
  endproperty
  a_rxset: assert property (p_rxset) else $error("rx ready missed");
  property p_txclr;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (wr_data_reg && !TX_OCTET_STB) |=> !status.tx_octet_taken;
  endproperty
  a_txclr: assert property (p_txclr) else $error("tx taken kept");
  property p_txset;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (TX_OCTET_STB && par_sel && running) |=> status.tx_octet_taken;
  endproperty
  a_txset: assert property (p_txset) else $error("tx taken missed");
  property p_mem;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (MEM_DONE_STB && running && !(WR_STB && ADDR == mpsr_pkg::ADDR_CTRL))
      |=> status.mem_access_done && !MEM_REQ;
  endproperty
  a_mem: assert property (p_mem) else $error("mem done missed");
  property p_busy;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (running && !PUMP.standby && PUMP.dialing) |=> status.pump_transmitting;
  endproperty
  a_busy: assert property (p_busy) else $error("busy missed");
  property p_init;
    @(posedge REF_CLK) disable iff (!RESET_N)
    !running |-> status.init_cycle_active;
  endproperty
  a_init: assert property (p_init) else $error("init flag low");
  sequence s_init_end;
    state == mpsr_pkg::MPSR_INIT &&
      init_cnt == ($clog2(INIT_CYCLES+1))'(INIT_CYCLES - 1);
  endsequence
  property p_init_end;
    @(posedge REF_CLK) disable iff (!RESET_N)
    s_init_end |=> running ##1 (!status.init_cycle_active && status.rx_octet_ready);
  endproperty
  a_init_end: assert property (p_init_end) else $error("init end wrong");
  property p_cset;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (running && !PUMP.standby && !PUMP.retrain_active && !PUMP.signal_lost &&
      PUMP.data_mode_ready) |=> status.carrier_present_flag;
  endproperty
  a_cset: assert property (p_cset) else $error("carrier not set");
  property p_cclr;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (PUMP.retrain_active || PUMP.signal_lost) |=> !status.carrier_present_flag;
  endproperty
  a_cclr: assert property (p_cclr) else $error("carrier not cleared");
  property p_rtset;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (running && !PUMP.standby && PUMP.mode_2400 && PUMP.retrain_request) |=> status.retrain_seen;
  endproperty
  a_rtset: assert property (p_rtset) else $error("retrain missed");
  property p_rtmode;
    @(posedge REF_CLK) disable iff (!RESET_N)
    !PUMP.mode_2400 |=> !status.retrain_seen;
  endproperty
  a_rtmode: assert property (p_rtmode) else $error("retrain outside mode");
  sequence s_tx_start;
    running && !PUMP.standby && PUMP.tx_data_started && SEND_REQUEST;
  endsequence
  property p_bset;
    @(posedge REF_CLK) disable iff (!RESET_N)
    s_tx_start |=> status.pump_transmitting;
  endproperty
  a_bset: assert property (p_bset) else $error("busy not set");
  property p_bhold;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (status.pump_transmitting && running && !PUMP.standby && !PUMP.tx_buffers_empty)
      |=> status.pump_transmitting;
  endproperty
  a_bhold: assert property (p_bhold) else $error("busy dropped early");
  property p_bdrop;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (running && !PUMP.dialing && !SEND_REQUEST && PUMP.tx_buffers_empty)
      |=> !status.pump_transmitting;
  endproperty
  a_bdrop: assert property (p_bdrop) else $error("busy kept");
  property p_rsvd;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (RD_STB && ADDR == mpsr_pkg::ADDR_STATUS) |=> !RD_DATA[3];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_rxoff;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (RX_OCTET_STB && !par_sel && !status.rx_octet_ready && !status.init_cycle_active)
      |=> !status.rx_octet_ready;
  endproperty
  a_rxoff: assert property (p_rxoff) else $error("rx set in serial mode");
  property p_txoff;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (TX_OCTET_STB && !par_sel && !status.tx_octet_taken) |=> !status.tx_octet_taken;
  endproperty
  a_txoff: assert property (p_txoff) else $error("tx set in serial mode");
endmodule
`default_nettype wire

// ==== sim/mpsr_host_model.sv ====
// Purpose: Host processor model on the parallel register bus.
// Assumes: Strobes are one-cycle pulses launched on the falling edge.
// Notes: Released write data shows its inverse, never the stale value.
`default_nettype none
module mpsr_host_model (
  input wire logic clk,
  input wire logic [7:0] rd_data,
  output logic [2:0] addr,
  output logic rd_stb,
  output logic wr_stb,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 3'h0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wr_data = 8'h00;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr_data = d;
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    wr_data = ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    d = rd_data;
  endtask
  // Host polls busy before going to standby; bounded so a stuck flag cannot hang
  task automatic wait_idle();
    logic [7:0] s;
    for (int i = 0; i < 50; i++) begin
      rd(mpsr_pkg::ADDR_STATUS, s);
      if (s[4] === 1'b0) break;
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/modem_pump_status_register_tb.sv ====
// Purpose: Self-checking bench for the pump status register bank.
// Assumes: Inputs change on the falling edge; short reset cycle parameter.
// Notes: Flags are checked by reading the status register.
`default_nettype none
module modem_pump_status_register_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT = 4;
  typedef struct packed {
    logic [7:0] ctrl;
    logic rts;
    logic send;
    logic par;
    logic irq;
  } mpsr_row_s;
  localparam mpsr_row_s ROWS [6] = '{'{8'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{8'h08, 1'b0, 1'b1, 1'b0, 1'b0}, '{8'h00, 1'b1, 1'b1, 1'b0, 1'b0},
    '{8'h10, 1'b0, 1'b0, 1'b1, 1'b0}, '{8'h40, 1'b0, 1'b0, 1'b0, 1'b1},
    '{8'ha0, 1'b0, 1'b0, 1'b0, 1'b0}};
  logic clk, rst_n, rts, rx_stb, tx_stb, mem_stb, rd_stb, wr_stb;
  logic mem_wr, mem_req, send, par, lso_n, irq;
  logic [2:0] addr;
  logic [7:0] rx_oct, wr_data, rd_data, tx_oct, d;
  logic [8:0] mem_addr;
  logic [15:0] mem_rd, mem_wd;
  mpsr_pkg::mpsr_pump_s pump;
  int fail_count, compares, cyc;
  mpsr_host_model host (.clk(clk), .rd_data(rd_data), .addr(addr), .rd_stb(rd_stb),
    .wr_stb(wr_stb), .wr_data(wr_data));
  mpsr_top #(.INIT_CYCLES(INIT)) uut (.REF_CLK(clk), .RESET_N(rst_n), .ADDR(addr),
    .RD_STB(rd_stb), .WR_STB(wr_stb), .WR_DATA(wr_data), .RD_DATA(rd_data),
    .RTS_PIN(rts), .PUMP(pump), .RX_OCTET_STB(rx_stb), .RX_OCTET(rx_oct),
    .TX_OCTET_STB(tx_stb), .TX_OCTET(tx_oct), .MEM_DONE_STB(mem_stb),
    .MEM_RD_DATA(mem_rd), .MEM_ADDR(mem_addr), .MEM_WR_DATA(mem_wd), .MEM_WR(mem_wr),
    .MEM_REQ(mem_req), .SEND_REQUEST(send), .PARALLEL_MODE(par),
    .LINE_SIGNAL_OUT_N(lso_n), .HOST_IRQ_OUT(irq));
  task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cw(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rs(input logic [7:0] e);
    logic [7:0] s;
    host.rd(mpsr_pkg::ADDR_STATUS, s);
    chk_val("status", {8'h00, e}, {8'h00, s});
  endtask
  // Carrier is raised on entry to data mode, so leave it first
  task automatic carrier_on(input logic [7:0] e);
    pump.data_mode_ready = 1'b0;
    cw(2);
    pump.data_mode_ready = 1'b1;
    cw(2);
    rs(e);
  endtask
  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    rts = 1'b0;
    rx_stb = 1'b0;
    tx_stb = 1'b0;
    mem_stb = 1'b0;
    rx_oct = 8'h00;
    mem_rd = 16'h0000;
    pump = '0;
    cw(5);
    chk_val("rd_data", 16'h0000, {8'h00, rd_data});
    chk_bit("line_n", 1'b1, lso_n);
    rst_n = 1'b1;
    rs(8'h01);
    cw(INIT + 4);
    rs(8'h40);
    for (int i = 0; i < 6; i++) begin
      host.wr(mpsr_pkg::ADDR_CTRL, ROWS[i].ctrl);
      rts = ROWS[i].rts;
      cw(1);
      chk_bit("send", ROWS[i].send, send);
      chk_bit("par", ROWS[i].par, par);
      chk_bit("irq", ROWS[i].irq, irq);
      host.rd(mpsr_pkg::ADDR_CTRL, d);
      chk_val("ctrl", {8'h00, ROWS[i].ctrl}, {8'h00, d});
    end
    rts = 1'b0;
    host.wr(mpsr_pkg::ADDR_CTRL, 8'h00);
    host.wr(mpsr_pkg::ADDR_STATUS, 8'hff);
    rs(8'h40);
    carrier_on(8'h42);
    chk_bit("line_n", 1'b0, lso_n);
    pump.retrain_active = 1'b1;
    cw(2);
    rs(8'h40);
    chk_bit("line_n", 1'b1, lso_n);
    pump.retrain_active = 1'b0;
    carrier_on(8'h42);
    pump.signal_lost = 1'b1;
    cw(2);
    rs(8'h40);
    pump.signal_lost = 1'b0;
    carrier_on(8'h42);
    pump.standby = 1'b1;
    cw(2);
    rs(8'h40);
    pump = '0;
    for (int m = 0; m < 2; m++) begin
      pump.mode_2400 = m[0];
      cw(1);
      pump.retrain_request = 1'b1;
      cw(1);
      pump.retrain_request = 1'b0;
      cw(1);
      rs(m ? 8'h44 : 8'h40);
    end
    pump = '0;
    host.wr(mpsr_pkg::ADDR_CTRL, 8'h08);
    pump.tx_data_started = 1'b1;
    cw(2);
    pump.tx_data_started = 1'b0;
    rs(8'h50);
    host.wr(mpsr_pkg::ADDR_CTRL, 8'h00);
    rs(8'h50);
    pump.tx_buffers_empty = 1'b1;
    host.wait_idle();
    rs(8'h40);
    pump.dialing = 1'b1;
    cw(2);
    rs(8'h50);
    pump.dialing = 1'b0;
    cw(2);
    rs(8'h40);
    pump.tx_buffers_empty = 1'b0;
    rts = 1'b1;
    pump.tx_data_started = 1'b1;
    cw(2);
    rs(8'h50);
    pump.standby = 1'b1;
    cw(2);
    rs(8'h40);
    pump = '0;
    rts = 1'b0;
    host.wr(mpsr_pkg::ADDR_RAM_ADR, 8'h5a);
    host.wr(mpsr_pkg::ADDR_CTRL, 8'h23);
    cw(1);
    chk_bit("mem_req", 1'b1, mem_req);
    chk_val("mem_addr", 16'h015a, {7'h00, mem_addr});
    chk_bit("irq", 1'b0, irq);
    mem_rd = 16'hbeef;
    mem_stb = 1'b1;
    cw(1);
    mem_stb = 1'b0;
    mem_rd = 16'h4110;
    cw(1);
    chk_bit("mem_req", 1'b0, mem_req);
    chk_bit("irq", 1'b1, irq);
    rs(8'h60);
    host.rd(mpsr_pkg::ADDR_RAM_LO, d);
    chk_val("ram_lo", 16'h00ef, {8'h00, d});
    host.rd(mpsr_pkg::ADDR_RAM_HI, d);
    chk_val("ram_hi", 16'h00be, {8'h00, d});
    chk_val("mem_wr_data", 16'hbeef, mem_wd);
    chk_bit("mem_wr", 1'b0, mem_wr);
    host.wr(mpsr_pkg::ADDR_CTRL, 8'h24);
    chk_bit("mem_wr", 1'b1, mem_wr);
    host.wr(mpsr_pkg::ADDR_CTRL, 8'hd0);
    host.rd(mpsr_pkg::ADDR_DATA, d);
    rs(8'h20);
    chk_bit("irq", 1'b0, irq);
    rx_oct = 8'h3c;
    rx_stb = 1'b1;
    cw(1);
    rx_stb = 1'b0;
    cw(1);
    chk_bit("irq", 1'b1, irq);
    rs(8'h60);
    host.rd(mpsr_pkg::ADDR_DATA, d);
    chk_val("par_data", 16'h003c, {8'h00, d});
    rs(8'h20);
    tx_stb = 1'b1;
    cw(1);
    tx_stb = 1'b0;
    rs(8'ha0);
    chk_bit("irq", 1'b1, irq);
    host.wr(mpsr_pkg::ADDR_DATA, 8'ha5);
    chk_val("tx_octet", 16'h00a5, {8'h00, tx_oct});
    rs(8'h20);
    host.wr(mpsr_pkg::ADDR_CTRL, 8'h00);
    rx_stb = 1'b1;
    tx_stb = 1'b1;
    cw(1);
    rx_stb = 1'b0;
    tx_stb = 1'b0;
    rs(8'h20);
    carrier_on(8'h22);
    rst_n = 1'b0;
    cw(1);
    chk_bit("line_n", 1'b1, lso_n);
    pump = '0;
    rst_n = 1'b1;
    rs(8'h01);
    cw(INIT + 4);
    rs(8'h40);
    final_report();
  end
endmodule
`default_nettype wire
